// *** rtl/sqp_consts.vh ***
`ifndef SQP_CONSTS_VH
`define SQP_CONSTS_VH

// ---------------------------------------------------------------
// Lane width encodings
// ---------------------------------------------------------------
`define SQP_W_SINGLE 2'h0
`define SQP_W_DUAL 2'h1
`define SQP_W_QUAD 2'h2
`define SQP_W_RSVD 2'h3
`define SQP_WIDTH_RESET 2'h0

// ---------------------------------------------------------------
// Transaction header fields
// ---------------------------------------------------------------
`define SQP_HDR_WR_BIT 7
`define SQP_HDR_SEL_HI 6
`define SQP_HDR_SEL_LO 4
`define SQP_SEL_REG 3'h0
`define SQP_SEL_RAM 3'h1

// ---------------------------------------------------------------
// Register offsets (byte wide registers)
// ---------------------------------------------------------------
`define SQP_REG_WIDTH 12'h000
`define SQP_REG_WPTR_LO 12'h001
`define SQP_REG_WPTR_HI 12'h002
`define SQP_REG_RPTR_LO 12'h003
`define SQP_REG_RPTR_HI 12'h004
`define SQP_REG_TIMER 12'h005
`define SQP_REG_IRQ 12'h006
`define SQP_REG_GPIO 12'h007
`define SQP_GPIO_RESET 4'h0
`define SQP_IRQ_CLR_BIT 0

// ---------------------------------------------------------------
// Command queue geometry
// ---------------------------------------------------------------
`define SQP_QUEUE_AW 12
`define SQP_QUEUE_BYTES 4096

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SQP_BYTE_BITS 4'h8
`define SQP_CLK_PERIOD_NS 100
`define SQP_TICK_NS 1000000
`define SQP_MS_CYCLES (`SQP_TICK_NS / `SQP_CLK_PERIOD_NS)

`endif

// *** rtl/sqp_cmd_ram.v ***
`timescale 1ns/1ps
`include "sqp_consts.vh"

module sqp_cmd_ram (
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Write port
   input wire we_i,
   input wire [`SQP_QUEUE_AW-1:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   // Read port
   input wire rd_en_i,
   input wire [`SQP_QUEUE_AW-1:0] rd_addr_i,
   output reg [7:0] rd_data_o
);

   reg [7:0] mem [0:`SQP_QUEUE_BYTES-1];

   always @(posedge clk_i) begin
      if (we_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end

endmodule

// *** rtl/sqp_top.v ***
`timescale 1ns/1ps
`include "sqp_consts.vh"

// Summary of operation
// - Out of reset the port moves one bit per clock, taking it on lane zero and answering on lane one.
// - Lane width field bits 1:0 select single (00), dual (01) or quad (10); 11 is reserved and is ignored.
// - A register write over the serial port itself switches to dual or quad lanes from the next transaction.
// - A 4 Kbyte command queue lives in internal memory, filled by the host and drained by the engine.
// - The engine fetches queued commands strictly in order and only once the host has posted them.
// - The read pointer advances only when the engine reports a command byte as executed.
// - On request the port raises an interrupt after a host given number of milliseconds.
// - Pending interrupts show on an active low interrupt output.
// - In quad mode lanes two and three take over pins that otherwise act as general purpose IO.
module sqp_top #(
   parameter MS_CYCLES = `SQP_MS_CYCLES
) (
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Serial link from the master
   input wire sck_i,
   input wire cs_n_i,
   // Data lanes
   input wire data_lane_zero_i,
   output reg data_lane_zero_o,
   output reg data_lane_zero_oe_o,
   input wire data_lane_one_i,
   output reg data_lane_one_o,
   output reg data_lane_one_oe_o,
   input wire data_lane_two_i,
   output reg data_lane_two_o,
   output reg data_lane_two_oe_o,
   input wire data_lane_three_i,
   output reg data_lane_three_o,
   output reg data_lane_three_oe_o,
   // Command stream to the graphics engine
   output reg [7:0] cmd_data_o,
   output reg cmd_valid_o,
   input wire cmd_ready_i,
   input wire cmd_done_i,
   // Interrupt to the host
   output reg int_n_o
);

   localparam PH_HDR0 = 2'h0;
   localparam PH_HDR1 = 2'h1;
   localparam PH_DUMMY = 2'h2;
   localparam PH_DATA = 2'h3;
   localparam [31:0] TICK_SPAN = MS_CYCLES - 1;
   localparam [13:0] TICK_LAST = TICK_SPAN[13:0];

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   reg sck_s1, sck_s2, sck_s3;
   reg cs_s1, cs_s2, cs_s3;
   reg [3:0] lane_s1, lane_s2;

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         lane_s1 <= 4'h0;
         lane_s2 <= 4'h0;
      end else begin
         sck_s1 <= sck_i;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         cs_s1 <= cs_n_i;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         lane_s1 <= {data_lane_three_i, data_lane_two_i, data_lane_one_i, data_lane_zero_i};
         lane_s2 <= lane_s1;
      end
   end

   wire rise = sck_s2 & ~sck_s3 & ~cs_s2;
   wire fall = ~sck_s2 & sck_s3 & ~cs_s2;
   wire cs_start = ~cs_s2 & cs_s3;

   // ---------------------------------------------------------------
   // Serial transaction engine
   // ---------------------------------------------------------------
   reg [1:0] lane_width;
   reg [1:0] act_w;
   reg [1:0] phase;
   reg [3:0] bit_cnt;
   reg [7:0] rx_shift;
   reg [7:0] tx_shift;
   reg [7:0] tx_byte;
   reg [3:0] tx_lanes;
   reg is_wr;
   reg [2:0] sel;
   reg [`SQP_QUEUE_AW-1:0] addr;
   reg load_pend;
   reg rd_req;
   reg host_pend;
   reg [7:0] reg_rd;
   reg [`SQP_QUEUE_AW-1:0] wptr;
   reg [`SQP_QUEUE_AW-1:0] rptr;
   reg [7:0] wp_lo;
   reg [3:0] gpio;
   reg [7:0] tmr_ms;
   reg irq_flag;
   wire [7:0] ram_q;

   wire [3:0] nb = (act_w == `SQP_W_QUAD) ? 4'h4 : (act_w == `SQP_W_DUAL) ? 4'h2 : 4'h1;
   wire [3:0] bit_sum = bit_cnt + nb;
   wire byte_done = rise & (bit_sum == `SQP_BYTE_BITS);
   wire [7:0] next_rx = (nb == 4'h4) ? {rx_shift[3:0], lane_s2[3:0]} :
                        (nb == 4'h2) ? {rx_shift[5:0], lane_s2[1:0]} : {rx_shift[6:0], lane_s2[0]};
   wire [7:0] next_tx = load_pend ? tx_byte :
                        (nb == 4'h4) ? {tx_shift[3:0], 4'h0} :
                        (nb == 4'h2) ? {tx_shift[5:0], 2'h0} : {tx_shift[6:0], 1'b0};
   wire data_wr = byte_done & (phase == PH_DATA) & is_wr;
   wire reg_wr = data_wr & (sel == `SQP_SEL_REG);
   wire mem_we = data_wr & (sel == `SQP_SEL_RAM);
   wire host_rd = rd_req & (sel == `SQP_SEL_RAM);

   always @(posedge clk_i) begin
      if (!resetn_i || cs_s2) begin
         phase <= PH_HDR0;
         bit_cnt <= 4'h0;
         load_pend <= 1'b0;
         rd_req <= 1'b0;
      end else begin
         rd_req <= 1'b0;
         if (rise) begin
            bit_cnt <= byte_done ? 4'h0 : bit_sum;
         end
         if (byte_done) begin
            case (phase)
               PH_HDR0: begin
                  phase <= PH_HDR1;
               end
               PH_HDR1: begin
                  phase <= is_wr ? PH_DATA : PH_DUMMY;
                  rd_req <= ~is_wr;
               end
               PH_DUMMY: begin
                  phase <= PH_DATA;
                  load_pend <= 1'b1;
               end
               PH_DATA: begin
                  load_pend <= ~is_wr;
               end
               default: begin
                  phase <= PH_HDR0;
               end
            endcase
         end else if (fall && load_pend) begin
            load_pend <= 1'b0;
            rd_req <= 1'b1;
         end
      end
   end

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         act_w <= `SQP_WIDTH_RESET;
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         tx_byte <= 8'h00;
         tx_lanes <= 4'h0;
         is_wr <= 1'b0;
         sel <= `SQP_SEL_REG;
         addr <= {`SQP_QUEUE_AW{1'b0}};
         host_pend <= 1'b0;
      end else begin
         host_pend <= host_rd;
         if (cs_start) begin
            act_w <= lane_width;
         end
         if (rise) begin
            rx_shift <= next_rx;
         end
         if (byte_done && phase == PH_HDR0) begin
            is_wr <= next_rx[`SQP_HDR_WR_BIT];
            sel <= next_rx[`SQP_HDR_SEL_HI:`SQP_HDR_SEL_LO];
            addr[11:8] <= next_rx[3:0];
         end
         if (byte_done && phase == PH_HDR1) begin
            addr[7:0] <= next_rx;
         end
         if (data_wr) begin
            addr <= addr + 12'h001;
         end
         if (fall) begin
            tx_shift <= next_tx;
            if (act_w == `SQP_W_QUAD) begin
               tx_lanes <= next_tx[7:4];
            end else if (act_w == `SQP_W_DUAL) begin
               tx_lanes <= {2'h0, next_tx[7:6]};
            end else begin
               tx_lanes <= {2'h0, next_tx[7], 1'b0};
            end
            if (load_pend) begin
               addr <= addr + 12'h001;
            end
         end
         if (rd_req && sel != `SQP_SEL_RAM) begin
            tx_byte <= reg_rd;
         end else if (host_pend) begin
            tx_byte <= ram_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   always @* begin
      case (addr)
         `SQP_REG_WIDTH: reg_rd = {6'h00, lane_width};
         `SQP_REG_WPTR_LO: reg_rd = wptr[7:0];
         `SQP_REG_WPTR_HI: reg_rd = {4'h0, wptr[11:8]};
         `SQP_REG_RPTR_LO: reg_rd = rptr[7:0];
         `SQP_REG_RPTR_HI: reg_rd = {4'h0, rptr[11:8]};
         `SQP_REG_TIMER: reg_rd = tmr_ms;
         `SQP_REG_IRQ: reg_rd = {7'h00, irq_flag};
         `SQP_REG_GPIO: reg_rd = {2'h0, lane_s2[3:2], gpio};
         default: reg_rd = 8'h00;
      endcase
   end

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         lane_width <= `SQP_WIDTH_RESET;
         wp_lo <= 8'h00;
         wptr <= {`SQP_QUEUE_AW{1'b0}};
         gpio <= `SQP_GPIO_RESET;
      end else if (reg_wr) begin
         case (addr)
            `SQP_REG_WIDTH: begin
               if (next_rx[1:0] != `SQP_W_RSVD) begin
                  lane_width <= next_rx[1:0];
               end
            end
            `SQP_REG_WPTR_LO: wp_lo <= next_rx;
            `SQP_REG_WPTR_HI: wptr <= {next_rx[3:0], wp_lo};
            `SQP_REG_GPIO: gpio <= next_rx[3:0];
            default: wp_lo <= wp_lo;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Millisecond timer and interrupt
   // ---------------------------------------------------------------
   reg [13:0] tick_cnt;
   reg [7:0] tmr_left;
   wire tmr_wr = reg_wr & (addr == `SQP_REG_TIMER);
   wire irq_clr = reg_wr & (addr == `SQP_REG_IRQ) & next_rx[`SQP_IRQ_CLR_BIT];
   wire tmr_fire = (tmr_left == 8'h01) & (tick_cnt == TICK_LAST);

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         tick_cnt <= 14'h0000;
         tmr_left <= 8'h00;
         tmr_ms <= 8'h00;
         irq_flag <= 1'b0;
         int_n_o <= 1'b1;
      end else begin
         if (tmr_wr) begin
            tmr_ms <= next_rx;
            tmr_left <= next_rx;
            tick_cnt <= 14'h0000;
         end else if (tmr_left != 8'h00) begin
            if (tick_cnt == TICK_LAST) begin
               tick_cnt <= 14'h0000;
               tmr_left <= tmr_left - 8'h01;
            end else begin
               tick_cnt <= tick_cnt + 14'h0001;
            end
         end
         irq_flag <= tmr_fire | (irq_flag & ~irq_clr);
         int_n_o <= ~irq_flag;
      end
   end

   // ---------------------------------------------------------------
   // Command queue and engine feed
   // ---------------------------------------------------------------
   reg [`SQP_QUEUE_AW-1:0] fptr;
   reg fetch_pend;
   reg [7:0] buf1;
   reg buf1_v;
   wire [1:0] used = {1'b0, cmd_valid_o} + {1'b0, buf1_v} + {1'b0, fetch_pend};
   wire fetch = (fptr != wptr) & ~host_rd & (used < 2'h2);
   wire pop = cmd_valid_o & cmd_ready_i;

   sqp_cmd_ram u_ram (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .we_i(mem_we),
      .wr_addr_i(addr),
      .wr_data_i(next_rx),
      .rd_en_i(host_rd | fetch),
      .rd_addr_i(host_rd ? addr : fptr),
      .rd_data_o(ram_q)
   );

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         fptr <= {`SQP_QUEUE_AW{1'b0}};
         rptr <= {`SQP_QUEUE_AW{1'b0}};
         fetch_pend <= 1'b0;
         cmd_data_o <= 8'h00;
         cmd_valid_o <= 1'b0;
         buf1 <= 8'h00;
         buf1_v <= 1'b0;
      end else begin
         fetch_pend <= fetch;
         if (fetch) begin
            fptr <= fptr + 12'h001;
         end
         if (cmd_done_i && rptr != wptr) begin
            rptr <= rptr + 12'h001;
         end
         if (pop && fetch_pend) begin
            cmd_data_o <= buf1_v ? buf1 : ram_q;
            buf1 <= ram_q;
         end else if (pop) begin
            cmd_data_o <= buf1;
            cmd_valid_o <= buf1_v;
            buf1_v <= 1'b0;
         end else if (fetch_pend) begin
            if (!cmd_valid_o) begin
               cmd_data_o <= ram_q;
               cmd_valid_o <= 1'b1;
            end else begin
               buf1 <= ram_q;
               buf1_v <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Lane pin drive
   // ---------------------------------------------------------------
   wire pin_quad = (lane_width == `SQP_W_QUAD);
   wire rd_drive = ~cs_s2 & ~is_wr & (phase == PH_DATA);

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         data_lane_zero_o <= 1'b0;
         data_lane_zero_oe_o <= 1'b0;
         data_lane_one_o <= 1'b0;
         data_lane_one_oe_o <= 1'b0;
         data_lane_two_o <= 1'b0;
         data_lane_two_oe_o <= 1'b0;
         data_lane_three_o <= 1'b0;
         data_lane_three_oe_o <= 1'b0;
      end else begin
         data_lane_zero_o <= tx_lanes[0];
         data_lane_zero_oe_o <= (act_w != `SQP_W_SINGLE) & rd_drive;
         data_lane_one_o <= tx_lanes[1];
         data_lane_one_oe_o <= (act_w == `SQP_W_SINGLE) ? ~cs_s2 : rd_drive;
         data_lane_two_o <= pin_quad ? tx_lanes[2] : gpio[0];
         data_lane_two_oe_o <= pin_quad ? (rd_drive & (act_w == `SQP_W_QUAD)) : gpio[2];
         data_lane_three_o <= pin_quad ? tx_lanes[3] : gpio[1];
         data_lane_three_oe_o <= pin_quad ? (rd_drive & (act_w == `SQP_W_QUAD)) : gpio[3];
      end
   end

endmodule

// *** sim/sqp_top_props.sv ***
`timescale 1ns/1ps
// -------------------------
// Port checks
// -------------------------
module sqp_top_props #(
   parameter MS_CYCLES = 20
) (
   input wire clk_i,
   input wire resetn_i,
   input wire sck_i,
   input wire cs_n_i,
   input wire data_lane_zero_oe_o,
   input wire data_lane_one_o,
   input wire data_lane_one_oe_o,
   input wire data_lane_two_oe_o,
   input wire data_lane_three_oe_o,
   input wire [7:0] cmd_data_o,
   input wire cmd_valid_o,
   input wire cmd_ready_i,
   input wire int_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence cs_idle;
      cs_n_i [*8];
   endsequence
   sequence irq_idle;
      (!int_n_o && cs_n_i) [*8];
   endsequence
   reset_idle_a: assert property (
      disable iff (1'b0) !resetn_i |=> int_n_o && !cmd_valid_o && !data_lane_one_oe_o)
      else $error("outputs active after reset");
   valid_hold_a: assert property (
      cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_data_o))
      else $error("command byte dropped while stalled");
   pop_drop_a: assert property ($fell(cmd_valid_o) |-> $past(cmd_ready_i))
      else $error("valid fell without a take");
   cs_quiet_a: assert property (
      cs_idle |-> !data_lane_zero_oe_o && !data_lane_one_oe_o)
      else $error("lane driven while deselected");
   idle_out_a: assert property (cs_idle |=> $stable(data_lane_one_o))
      else $error("reply moved while deselected");
   gpio_hold_a: assert property (
      cs_idle |=> $stable(data_lane_two_oe_o) && $stable(data_lane_three_oe_o))
      else $error("shared pins changed while deselected");
   irq_hold_a: assert property (irq_idle |=> !int_n_o)
      else $error("interrupt dropped without a clear");
   reply_fall_a: assert property (
      data_lane_one_oe_o && $past(data_lane_one_oe_o) && $changed(data_lane_one_o) |-> !$past(sck_i, 2))
      else $error("reply changed on rising clock");
endmodule

bind sqp_top sqp_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (
   .clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
   .data_lane_zero_oe_o(data_lane_zero_oe_o), .data_lane_one_o(data_lane_one_o),
   .data_lane_one_oe_o(data_lane_one_oe_o), .data_lane_two_oe_o(data_lane_two_oe_o),
   .data_lane_three_oe_o(data_lane_three_oe_o), .cmd_data_o(cmd_data_o),
   .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .int_n_o(int_n_o)
);

// *** sim/sqp_host_model.sv ***
`timescale 1ns/1ps
// -------------------------
// Serial master
// -------------------------
module sqp_host_model (
   // Link
   output reg sck_o,
   output reg cs_n_o,
   // Lanes
   output reg [3:0] lane_o,
   output reg [3:0] lane_oe_o,
   input wire [3:0] pin_i
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      lane_o = 4'h0;
      lane_oe_o = 4'h0;
   end
   task frame_begin;
      begin
         #37 cs_n_o = 1'b0;
         #500;
      end
   endtask
   task frame_end;
      begin
         #300 cs_n_o = 1'b1;
         lane_oe_o = 4'h0;
         #900;
      end
   endtask
   task stray;
      begin
         repeat (8) begin
            #400 sck_o = 1'b1;
            #400 sck_o = 1'b0;
         end
      end
   endtask
   task xfer_byte(input [7:0] tx, input [1:0] w, input rd, output [7:0] rx);
      integer n, u;
      reg [7:0] sh;
      begin
         n = (w == 2'h0) ? 1 : (w == 2'h1) ? 2 : 4;
         sh = tx;
         rx = 8'h00;
         for (u = 0; u < 8 / n; u = u + 1) begin
            lane_oe_o = (w == 2'h0) ? 4'h1 : rd ? 4'h0 : 4'hf >> (4 - n);
            lane_o = sh[7:4] >> (4 - n);
            sh = sh << n;
            #250 sck_o = 1'b1;
            #300;
            rx = (rx << n) | ((w == 2'h0) ? {7'h00, pin_i[1]} : {4'h0, pin_i & (4'hf >> (4 - n))});
            sck_o = 1'b0;
            #250;
         end
      end
   endtask
endmodule

// *** sim/tb_sqp_top.sv ***
`timescale 1ns/1ps
module tb_sqp_top;
   localparam MS = 20;
   reg clk_i = 1'b0;
   reg resetn_i = 1'b0;
   reg cmd_ready_i = 1'b0;
   reg cmd_done_i = 1'b0;
   reg auto_done = 1'b0;
   reg man_done = 1'b0;
   reg noise = 1'b0;
   reg [1:0] w = 2'h0;
   reg [1:0] m, e;
   reg [7:0] modes = 8'b00_10_11_01;
   reg [7:0] q;
   reg [7:0] got[$];
   integer fails = 0;
   integer check_count = 0;
   integer i;
   wire sck, cs_n, cmd_valid_o, int_n_o;
   wire [3:0] host_o, host_oe, pin, dut_o, dut_oe;
   wire [7:0] cmd_data_o;
   // Undriven lanes float to a toggling level
   assign pin = (dut_oe & dut_o) | (~dut_oe & host_oe & host_o) | (~dut_oe & ~host_oe & {4{noise}});
   sqp_host_model host (.sck_o(sck), .cs_n_o(cs_n), .lane_o(host_o), .lane_oe_o(host_oe), .pin_i(pin));
   sqp_top #(.MS_CYCLES(MS)) dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
      .data_lane_zero_i(pin[0]), .data_lane_zero_o(dut_o[0]), .data_lane_zero_oe_o(dut_oe[0]),
      .data_lane_one_i(pin[1]), .data_lane_one_o(dut_o[1]), .data_lane_one_oe_o(dut_oe[1]),
      .data_lane_two_i(pin[2]), .data_lane_two_o(dut_o[2]), .data_lane_two_oe_o(dut_oe[2]),
      .data_lane_three_i(pin[3]), .data_lane_three_o(dut_o[3]), .data_lane_three_oe_o(dut_oe[3]),
      .cmd_data_o(cmd_data_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
      .cmd_done_i(cmd_done_i), .int_n_o(int_n_o));
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      noise <= ~noise;
      cmd_done_i <= man_done | (auto_done & cmd_valid_o & cmd_ready_i);
      if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) got.push_back(cmd_data_o);
   end
   task check(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task xact(input wr, input [2:0] sel, input [11:0] a, input [7:0] d);
      reg [7:0] dm;
      begin
         host.frame_begin;
         host.xfer_byte({wr, sel, a[11:8]}, w, 1'b0, dm);
         host.xfer_byte(a[7:0], w, 1'b0, dm);
         if (!wr) host.xfer_byte(8'h00, w, 1'b0, dm);
         host.xfer_byte(d, w, !wr, q);
         host.frame_end;
         @(posedge clk_i);
      end
   endtask
   task rd(input string nm, input [11:0] a, input [7:0] ex);
      begin
         xact(1'b0, 3'h0, a, 8'h00);
         check(nm, q, ex);
      end
   endtask
   task wptr(input [11:0] p);
      begin
         xact(1'b1, 3'h0, 12'h001, p[7:0]);
         xact(1'b1, 3'h0, 12'h002, {4'h0, p[11:8]});
      end
   endtask
   // The feed bubbles once every third cycle, so a full drain needs about 1.5 cycles a byte
   task wait_got(input integer n);
      begin
         for (i = 0; i < 8000 && got.size() < n; i = i + 1) @(posedge clk_i);
         @(negedge clk_i);
      end
   endtask
   task end_of_test;
      begin
         $display("Checks %0d mismatches %0d", check_count, fails);
         if (fails == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      fails = fails + 1;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("idle outs", {cmd_valid_o, int_n_o, dut_oe}, 16'h0010);
      rd("width", 12'h000, 8'h00);
      for (i = 0; i < 3; i = i + 1) xact(1'b1, 3'h1, i[11:0], 8'ha1 + i * 8'h11);
      wptr(12'h003);
      repeat (20) @(posedge clk_i);
      check("stalled", {cmd_valid_o, cmd_data_o}, 16'h01a1);
      cmd_ready_i <= 1'b1;
      wait_got(3);
      check("cmd bytes", {got[0], got[1]}, 16'ha1b2);
      check("cmd last", got[2], 16'h00c3);
      rd("rptr", 12'h003, 8'h00);
      repeat (3) begin
         man_done <= 1'b1;
         @(posedge clk_i);
         man_done <= 1'b0;
         @(posedge clk_i);
      end
      xact(1'b1, 3'h0, 12'h003, 8'h55);
      rd("rptr ro", 12'h003, 8'h03);
      auto_done <= 1'b1;
      got.delete();
      wptr(12'hfff);
      wait_got(4092);
      check("drained", got.size(), 16'd4092);
      got.delete();
      xact(1'b1, 3'h1, 12'hfff, 8'h5a);
      xact(1'b1, 3'h1, 12'h000, 8'h6b);
      wptr(12'h001);
      wait_got(2);
      check("wrap", {got[0], got[1]}, 16'h5a6b);
      check("empty", cmd_valid_o, 16'h0000);
      rd("rptr wrap", 12'h003, 8'h01);
      rd("rptr hi", 12'h004, 8'h00);
      xact(1'b1, 3'h0, 12'h007, 8'h0d);
      check("gpio", {dut_oe[3:2], dut_o[3:2]}, 16'h000d);
      rd("gpio rd", 12'h007, 8'h1d);
      for (i = 0; i < 4; i = i + 1) begin
         m = modes[2 * i +: 2];
         e = (m == 2'h3) ? w : m;
         xact(1'b1, 3'h0, 12'h000, {6'h00, m});
         w = e;
         rd("width", 12'h000, {6'h00, e});
         if (e == 2'h2) check("quad pins", dut_oe[3:2], 16'h0000);
      end
      check("gpio back", {dut_oe[3:2], dut_o[3:2]}, 16'h000d);
      host.stray;
      rd("deselected", 12'h000, 8'h00);
      xact(1'b1, 3'h0, 12'h005, 8'h02);
      for (i = 0; i < 200 && int_n_o !== 1'b0; i = i + 1) @(posedge clk_i);
      check("timer", (i > 2 * MS - 20) && (i <= 2 * MS + 2), 16'h0001);
      repeat (30) @(posedge clk_i);
      check("irq held", int_n_o, 16'h0000);
      xact(1'b1, 3'h0, 12'h006, 8'h01);
      check("irq clear", int_n_o, 16'h0001);
      rd("irq flag", 12'h006, 8'h00);
      rd("unmapped", 12'h0ff, 8'h00);
      end_of_test;
   end
endmodule
